// File: inc/adcr_pkg.sv
// Package: register map, field layout, reset values and timing constants of the DSP config bank
package adcr_pkg;

  // Register indices; byte address is four times the index
  localparam logic [7:0] IDX_EQ_FIRST    = 8'h05;
  localparam logic [7:0] IDX_EQ_LAST     = 8'h0E;
  localparam logic [7:0] IDX_BYPASS      = 8'h0F;
  localparam logic [7:0] IDX_COMPRESSOR  = 8'h10;
  localparam logic [7:0] IDX_TONE        = 8'h11;
  localparam logic [7:0] IDX_PROT_STATUS = 8'h20;

  localparam int EQ_BANDS = 5;
  localparam int EQ_WORDS = 10;

  // Equalizer word one fields
  localparam int W1_FLAG_POS  = 15;
  localparam int W1_MANT_LSB  = 4;
  localparam int W1_MANT_W    = 11;
  localparam int W1_EXP_LSB   = 0;
  localparam int W1_EXP_W     = 4;
  // Equalizer word two fields
  localparam int W2_FLAG_POS  = 15;
  localparam int W2_MANT_LSB  = 11;
  localparam int W2_MANT_W    = 4;
  localparam int W2_EXP_LSB   = 8;
  localparam int W2_EXP_W     = 3;
  localparam int W2_GAIN_LSB  = 1;
  localparam int W2_GAIN_W    = 7;
  localparam int W2_SCALE_POS = 0;

  // Bypass and protection word
  localparam int BP_OCP_LSB  = 6;
  localparam int BP_OTP_LSB  = 4;
  localparam int BP_CLIP_POS = 3;
  localparam int BP_HPF_POS  = 2;
  localparam int BP_DRC_POS  = 1;
  localparam int BP_EQ_POS   = 0;

  // Compressor word
  localparam int DRC_ATTACK_LEVEL_LSB  = 12;
  localparam int DRC_ATTACK_SPEED_LSB = 8;
  localparam int DRC_RELEASE_LEVEL_LSB  = 4;
  localparam int DRC_RELEASE_SPEED_LSB = 0;

  // Tone word
  localparam int TONE_TRB_GAIN_LSB = 9;
  localparam int TONE_TRB_FREQ_LSB = 7;
  localparam int TONE_BAS_GAIN_LSB = 2;
  localparam int TONE_BAS_FREQ_LSB = 0;

  // Reset values and writable masks
  localparam logic [15:0] EQ_WORD_RESET     = 16'h0000;
  localparam logic [15:0] BYPASS_RESET      = 16'h0093;
  localparam logic [15:0] BYPASS_MASK       = 16'h00FF;
  localparam logic [15:0] COMPRESSOR_RESET  = 16'h92BA;
  localparam logic [15:0] TONE_RESET        = 16'h12A5;
  localparam logic [15:0] TONE_MASK         = 16'h3FFF;

  // Float timer codes
  localparam logic [1:0] FLOAT_CODE_HOLD = 2'b11;

  // Timing at the 125 MHz bus clock
  localparam int CLK_PERIOD_NS      = 8;
  localparam int FLOAT_SHORT_NS     = 4500;
  localparam int FLOAT_OCP_MID_NS   = 27500;
  localparam int FLOAT_OCP_LONG_MS  = 10;
  localparam int FLOAT_OTP_MID_MS   = 100;
  localparam int FLOAT_OTP_LONG_S   = 1;
  localparam int FLOAT_SHORT_CYC    = (FLOAT_SHORT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int FLOAT_OCP_MID_CYC  = (FLOAT_OCP_MID_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int FLOAT_OCP_LONG_CYC = FLOAT_OCP_LONG_MS * 1000000 / CLK_PERIOD_NS;
  localparam int FLOAT_OTP_MID_CYC  = FLOAT_OTP_MID_MS * 1000000 / CLK_PERIOD_NS;
  localparam int FLOAT_OTP_LONG_CYC = FLOAT_OTP_LONG_S * 1000000000 / CLK_PERIOD_NS;
  localparam int FLOAT_CNT_W        = 27;

endpackage : adcr_pkg

// File: design/adcr_pin_sync.sv
// Three-stage synchroniser for an asynchronous pin level
`timescale 1ns/100ps
`default_nettype none
module adcr_pin_sync
(
  // Clock and reset
  input  wire logic hclk,
  input  wire logic hresetn,
  // Pin in, clean level out
  input  wire logic pin_async,
  output var  logic level_reg
);

  logic meta_reg;
  logic s2_reg;
  logic s3_reg;

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      meta_reg <= 1'b0;
      s2_reg   <= 1'b0;
      s3_reg   <= 1'b0;
    end
    else
    begin
      meta_reg <= pin_async;
      s2_reg   <= meta_reg;
      s3_reg   <= s2_reg;
    end
  end

  // Level only moves once two settled stages agree
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      level_reg <= 1'b0;
    else if (s2_reg == s3_reg)
      level_reg <= s3_reg;
  end

endmodule : adcr_pin_sync
`default_nettype wire

// File: design/adcr_float_timer.sv
// Power stage float timer for one protection source
`timescale 1ns/100ps
`default_nettype none
module adcr_float_timer
#(
  parameter int CNT_W  = 27,
  parameter int CYC_00 = 563,
  parameter int CYC_01 = 3438,
  parameter int CYC_10 = 1250000
)
(
  // Clock and reset
  input  wire logic             hclk,
  input  wire logic             hresetn,
  // Fault and time selection
  input  wire logic             fault,
  input  wire logic [1:0]       time_sel,
  // Float state
  output var  logic             floating_reg
);

  logic [CNT_W-1:0] count_reg;
  logic             hold_reg;

  // Time code is latched at the fault so a rewrite cannot cut a float short
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      floating_reg <= 1'b0;
      hold_reg     <= 1'b0;
      count_reg    <= '0;
    end
    else if (!floating_reg)
    begin
      if (fault)
      begin
        floating_reg <= 1'b1;
        hold_reg     <= (time_sel == adcr_pkg::FLOAT_CODE_HOLD);
        case (time_sel)
          2'b00:   count_reg <= CNT_W'(CYC_00 - 1);
          2'b01:   count_reg <= CNT_W'(CYC_01 - 1);
          2'b10:   count_reg <= CNT_W'(CYC_10 - 1);
          default: count_reg <= '0;
        endcase
      end
    end
    else if (!hold_reg)
    begin
      if (count_reg == '0)
        floating_reg <= 1'b0;
      else
        count_reg <= count_reg - 1'b1;
    end
  end

endmodule : adcr_float_timer
`default_nettype wire

// File: design/adcr_config_regs.sv
// AHB-Lite register bank holding the sound processor configuration
//
// How it works
// R1 - Word one: flag, 11-bit mantissa, 4-bit exponent
// R2 - Word two: flag, mantissa, exponent, 7-bit gain
// R3 - Word two bit 0 selects 6 dB attenuation
// R4 - Band words at indices 05h to 0Eh
// R5 - Overcurrent float time from 2-bit code
// R6 - Overtemperature float time from 2-bit code
// R7 - Clip bit: 0 smooth clipping, 1 off
// R8 - Bypass bits for high-pass, compressor, equalizer
// R9 - Compressor attack level and rate fields
// R10 - Compressor release level and rate fields
// R11 - Treble gain 5-bit code, default 0 dB
// R12 - Bass gain 5-bit code, default 0 dB
// R13 - Treble and bass corner selects, reset 01
// R14 - Fields read back; reserved bits read zero
`timescale 1ns/100ps
`default_nettype none
module adcr_config_regs
#(
  parameter int OCP_LONG_CYC = adcr_pkg::FLOAT_OCP_LONG_CYC,
  parameter int OTP_MID_CYC  = adcr_pkg::FLOAT_OTP_MID_CYC,
  parameter int OTP_LONG_CYC = adcr_pkg::FLOAT_OTP_LONG_CYC
)
(
  // Clock and reset
  input  wire logic        hclk,
  input  wire logic        hresetn,
  // AHB-Lite slave
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output var  logic        hreadyout,
  output var  logic        hresp,
  output var  logic [31:0] hrdata,
  // Protection pins
  input  wire logic        overcurrent_detect,
  input  wire logic        overtemp_detect,
  output var  logic        power_stage_float,
  // Equalizer coefficients, band A in the lowest slice
  output wire logic [4:0]  band_cfg_flag_one,
  output wire logic [54:0] band_coef_one_mantissa,
  output wire logic [19:0] band_coef_one_exponent,
  output wire logic [4:0]  band_cfg_flag_two,
  output wire logic [19:0] band_coef_two_mantissa,
  output wire logic [14:0] band_coef_two_exponent,
  output wire logic [34:0] band_gain_param,
  output wire logic [4:0]  band_scale_factor,
  // Signal path control
  output wire logic        clip_smoothing_bypass,
  output wire logic        highpass_bypass,
  output wire logic        compressor_bypass,
  output wire logic        equalizer_bypass,
  // Compressor
  output wire logic [3:0]  attack_level,
  output wire logic [3:0]  attack_speed,
  output wire logic [3:0]  release_level,
  output wire logic [3:0]  release_speed,
  // Tone
  output wire logic [4:0]  high_shelf_gain,
  output wire logic [1:0]  high_shelf_corner,
  output wire logic [4:0]  low_shelf_gain,
  output wire logic [1:0]  low_shelf_corner
);

  typedef enum logic [1:0] {
    ST_IDLE,
    ST_WRITE,
    ST_READ
  } adcr_phase_t;

  adcr_phase_t phase_reg;
  logic [7:0]  addr_idx_reg;
  logic        addr_ok_reg;

  logic [15:0] eq_word_reg [adcr_pkg::EQ_WORDS];
  logic [15:0] bypass_reg;
  logic [15:0] compressor_reg;
  logic [15:0] tone_reg;

  logic        ocp_level;
  logic        otp_level;
  logic        ocp_floating;
  logic        otp_floating;

  logic        addr_take;
  logic        addr_word_ok;
  logic        wr_en;
  logic [15:0] wr_data;
  logic [15:0] rd_value;
  logic [3:0]  eq_slot;
  logic [15:0] status_value;

  // Address phase
  assign addr_take    = hsel && hready && htrans[1];
  // Only aligned words below 256 indices decode; everything else reads as zero
  assign addr_word_ok = (haddr[1:0] == 2'b00) && (haddr[31:10] == 22'h00_0000);

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      phase_reg    <= ST_IDLE;
      addr_idx_reg <= 8'h00;
      addr_ok_reg  <= 1'b0;
    end
    else
    begin
      case (phase_reg)
        ST_IDLE,
        ST_WRITE:
        begin
          if (addr_take)
          begin
            phase_reg    <= hwrite ? ST_WRITE : ST_READ;
            addr_idx_reg <= haddr[9:2];
            addr_ok_reg  <= addr_word_ok;
          end
          else
            phase_reg <= ST_IDLE;
        end
        // One wait state lets a preceding write land before the read is sampled
        ST_READ:
          phase_reg <= ST_IDLE;
        default:
          phase_reg <= ST_IDLE;
      endcase
    end
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      hreadyout <= 1'b1;
    else if (phase_reg == ST_READ)
      hreadyout <= 1'b1;
    else if (addr_take && !hwrite)
      hreadyout <= 1'b0;
  end

  // Slave never signals an error
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      hresp <= 1'b0;
    else
      hresp <= 1'b0;
  end

  assign wr_en   = (phase_reg == ST_WRITE) && addr_ok_reg;
  assign wr_data = hwdata[15:0];
  assign eq_slot = 4'(addr_idx_reg - adcr_pkg::IDX_EQ_FIRST);

  // Equalizer storage, one word per index
  genvar gw;
  generate
    for (gw = 0; gw < adcr_pkg::EQ_WORDS; gw++)
    begin : g_eq_word
      always_ff @(posedge hclk or negedge hresetn)
      begin
        if (!hresetn)
          eq_word_reg[gw] <= adcr_pkg::EQ_WORD_RESET;
        else if (wr_en && (addr_idx_reg >= adcr_pkg::IDX_EQ_FIRST)
                 && (addr_idx_reg <= adcr_pkg::IDX_EQ_LAST) && (eq_slot == 4'(gw))) // R4
          eq_word_reg[gw] <= wr_data;
      end
    end
  endgenerate

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      bypass_reg <= adcr_pkg::BYPASS_RESET; // R8
    else if (wr_en && addr_idx_reg == adcr_pkg::IDX_BYPASS)
      bypass_reg <= wr_data & adcr_pkg::BYPASS_MASK; // R14
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      compressor_reg <= adcr_pkg::COMPRESSOR_RESET; // R9 R10
    else if (wr_en && addr_idx_reg == adcr_pkg::IDX_COMPRESSOR)
      compressor_reg <= wr_data;
  end

  // Reserved gain codes are stored as written; the filter clamps them
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      tone_reg <= adcr_pkg::TONE_RESET; // R11 R12 R13
    else if (wr_en && addr_idx_reg == adcr_pkg::IDX_TONE)
      tone_reg <= wr_data & adcr_pkg::TONE_MASK; // R14
  end

  // Read mux
  assign status_value = {12'h000, otp_level, ocp_level, otp_floating, ocp_floating};

  always_comb
  begin
    rd_value = 16'h0000;
    if (addr_ok_reg)
    begin
      if (addr_idx_reg >= adcr_pkg::IDX_EQ_FIRST && addr_idx_reg <= adcr_pkg::IDX_EQ_LAST)
        rd_value = eq_word_reg[eq_slot]; // R14
      else if (addr_idx_reg == adcr_pkg::IDX_BYPASS)
        rd_value = bypass_reg;
      else if (addr_idx_reg == adcr_pkg::IDX_COMPRESSOR)
        rd_value = compressor_reg;
      else if (addr_idx_reg == adcr_pkg::IDX_TONE)
        rd_value = tone_reg;
      else if (addr_idx_reg == adcr_pkg::IDX_PROT_STATUS)
        rd_value = status_value;
    end
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      hrdata <= 32'h0000_0000;
    else if (phase_reg == ST_READ)
      hrdata <= {16'h0000, rd_value}; // R14
  end

  // Protection
  adcr_pin_sync u_ocp_sync
  (
    .hclk      (hclk),
    .hresetn   (hresetn),
    .pin_async (overcurrent_detect),
    .level_reg (ocp_level)
  );

  adcr_pin_sync u_otp_sync
  (
    .hclk      (hclk),
    .hresetn   (hresetn),
    .pin_async (overtemp_detect),
    .level_reg (otp_level)
  );

  adcr_float_timer
  #(
    .CNT_W  (adcr_pkg::FLOAT_CNT_W),
    .CYC_00 (adcr_pkg::FLOAT_SHORT_CYC),
    .CYC_01 (adcr_pkg::FLOAT_OCP_MID_CYC),
    .CYC_10 (OCP_LONG_CYC)
  )
  u_ocp_timer // R5
  (
    .hclk         (hclk),
    .hresetn      (hresetn),
    .fault        (ocp_level),
    .time_sel     (bypass_reg[adcr_pkg::BP_OCP_LSB +: 2]),
    .floating_reg (ocp_floating)
  );

  adcr_float_timer
  #(
    .CNT_W  (adcr_pkg::FLOAT_CNT_W),
    .CYC_00 (adcr_pkg::FLOAT_SHORT_CYC),
    .CYC_01 (OTP_MID_CYC),
    .CYC_10 (OTP_LONG_CYC)
  )
  u_otp_timer // R6
  (
    .hclk         (hclk),
    .hresetn      (hresetn),
    .fault        (otp_level),
    .time_sel     (bypass_reg[adcr_pkg::BP_OTP_LSB +: 2]),
    .floating_reg (otp_floating)
  );

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      power_stage_float <= 1'b0;
    else
      power_stage_float <= ocp_floating || otp_floating; // R5 R6
  end

  // Field fan-out, all straight from storage flops
  genvar gb;
  generate
    for (gb = 0; gb < adcr_pkg::EQ_BANDS; gb++)
    begin : g_band
      assign band_cfg_flag_one[gb] = eq_word_reg[2*gb][adcr_pkg::W1_FLAG_POS]; // R1
      assign band_coef_one_mantissa[gb*11 +: 11] =
        eq_word_reg[2*gb][adcr_pkg::W1_MANT_LSB +: adcr_pkg::W1_MANT_W]; // R1
      assign band_coef_one_exponent[gb*4 +: 4] =
        eq_word_reg[2*gb][adcr_pkg::W1_EXP_LSB +: adcr_pkg::W1_EXP_W]; // R1
      assign band_cfg_flag_two[gb] = eq_word_reg[2*gb+1][adcr_pkg::W2_FLAG_POS]; // R2
      assign band_coef_two_mantissa[gb*4 +: 4] =
        eq_word_reg[2*gb+1][adcr_pkg::W2_MANT_LSB +: adcr_pkg::W2_MANT_W]; // R2
      assign band_coef_two_exponent[gb*3 +: 3] =
        eq_word_reg[2*gb+1][adcr_pkg::W2_EXP_LSB +: adcr_pkg::W2_EXP_W]; // R2
      assign band_gain_param[gb*7 +: 7] =
        eq_word_reg[2*gb+1][adcr_pkg::W2_GAIN_LSB +: adcr_pkg::W2_GAIN_W]; // R2
      assign band_scale_factor[gb] = eq_word_reg[2*gb+1][adcr_pkg::W2_SCALE_POS]; // R3
    end
  endgenerate

  assign clip_smoothing_bypass = bypass_reg[adcr_pkg::BP_CLIP_POS]; // R7
  assign highpass_bypass       = bypass_reg[adcr_pkg::BP_HPF_POS]; // R8
  assign compressor_bypass     = bypass_reg[adcr_pkg::BP_DRC_POS]; // R8
  assign equalizer_bypass      = bypass_reg[adcr_pkg::BP_EQ_POS]; // R8

  assign attack_level  = compressor_reg[adcr_pkg::DRC_ATTACK_LEVEL_LSB +: 4]; // R9
  assign attack_speed  = compressor_reg[adcr_pkg::DRC_ATTACK_SPEED_LSB +: 4]; // R9
  assign release_level = compressor_reg[adcr_pkg::DRC_RELEASE_LEVEL_LSB +: 4]; // R10
  assign release_speed = compressor_reg[adcr_pkg::DRC_RELEASE_SPEED_LSB +: 4]; // R10

  assign high_shelf_gain   = tone_reg[adcr_pkg::TONE_TRB_GAIN_LSB +: 5]; // R11
  assign high_shelf_corner = tone_reg[adcr_pkg::TONE_TRB_FREQ_LSB +: 2]; // R13
  assign low_shelf_gain    = tone_reg[adcr_pkg::TONE_BAS_GAIN_LSB +: 5]; // R12
  assign low_shelf_corner  = tone_reg[adcr_pkg::TONE_BAS_FREQ_LSB +: 2]; // R13

endmodule : adcr_config_regs
`default_nettype wire

// File: test/adcr_config_regs_props.sv
// Checker for the config bank bus timing and field outputs
`timescale 1ns/100ps
`default_nettype none
module adcr_config_regs_props
(
  // Clock and reset
  input wire logic        hclk,
  input wire logic        hresetn,
  // Bus
  input wire logic        hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0]  htrans,
  input wire logic        hwrite,
  input wire logic [31:0] hwdata,
  input wire logic        hready,
  input wire logic        hreadyout,
  input wire logic        hresp,
  input wire logic [31:0] hrdata,
  // Protection
  input wire logic        overcurrent_detect,
  input wire logic        overtemp_detect,
  input wire logic        power_stage_float,
  // Fields
  input wire logic [4:0]  band_cfg_flag_one,
  input wire logic [54:0] band_coef_one_mantissa,
  input wire logic [19:0] band_coef_one_exponent,
  input wire logic        clip_smoothing_bypass,
  input wire logic        highpass_bypass,
  input wire logic        compressor_bypass,
  input wire logic        equalizer_bypass,
  input wire logic [4:0]  high_shelf_gain,
  input wire logic [1:0]  high_shelf_corner,
  input wire logic [4:0]  low_shelf_gain,
  input wire logic [1:0]  low_shelf_corner
);
  logic        take;
  logic [3:0]  quiet_cnt;
  logic [15:0] wd_q;
  assign take = hsel && hready && htrans[1];
  // Float may only start shortly after a fault pin was high
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      quiet_cnt <= 4'h0;
    else if (overcurrent_detect || overtemp_detect)
      quiet_cnt <= 4'h0;
    else if (quiet_cnt != 4'hF)
      quiet_cnt <= quiet_cnt + 4'h1;
  end
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      wd_q <= 16'h0000;
    else
      wd_q <= hwdata[15:0];
  end
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  hresp_okay_a: assert property (hresp == 1'b0)
    else $error("hresp not OKAY");
  read_wait_a: assert property (take && !hwrite |=> !hreadyout ##1 hreadyout)
    else $error("read wait state wrong");
  write_nowait_a: assert property (take && hwrite |=> hreadyout)
    else $error("write stalled");
  rdata_upper_a: assert property (hrdata[31:16] == 16'h0000)
    else $error("upper read bits set");
  bypass_reset_a: assert property ($rose(hresetn) |-> !power_stage_float &&
    {clip_smoothing_bypass, highpass_bypass, compressor_bypass, equalizer_bypass} == 4'h3)
    else $error("bypass bits not at reset value");
  tone_reset_a: assert property ($rose(hresetn) |->
    {high_shelf_gain, high_shelf_corner, low_shelf_gain, low_shelf_corner} == 14'h12A5)
    else $error("tone fields not at reset value");
  eq_word_load_a: assert property (take && hwrite && haddr == 32'h0000_0014 ##1 1'b1 |=>
    {band_cfg_flag_one[0], band_coef_one_mantissa[10:0], band_coef_one_exponent[3:0]} == wd_q)
    else $error("band word one not loaded");
  bypass_load_a: assert property (take && hwrite && haddr == 32'h0000_003C ##1 1'b1 |=>
    {clip_smoothing_bypass, highpass_bypass, compressor_bypass, equalizer_bypass} == wd_q[3:0])
    else $error("bypass bits not loaded");
  tone_load_a: assert property (take && hwrite && haddr == 32'h0000_0044 ##1 1'b1 |=>
    {high_shelf_gain, high_shelf_corner, low_shelf_gain, low_shelf_corner} == wd_q[13:0])
    else $error("tone fields not loaded");
  float_cause_a: assert property ($rose(power_stage_float) |-> quiet_cnt < 4'hA)
    else $error("float without fault");
  read_c: cover property (take && !hwrite);
  bypass_wr_c: cover property (take && hwrite && haddr == 32'h0000_003C);
  float_c: cover property ($rose(power_stage_float));
endmodule : adcr_config_regs_props
bind adcr_config_regs adcr_config_regs_props i_props (.hclk, .hresetn, .hsel, .haddr,
  .htrans, .hwrite, .hwdata, .hready, .hreadyout, .hresp, .hrdata, .overcurrent_detect,
  .overtemp_detect, .power_stage_float, .band_cfg_flag_one, .band_coef_one_mantissa,
  .band_coef_one_exponent, .clip_smoothing_bypass, .highpass_bypass, .compressor_bypass,
  .equalizer_bypass, .high_shelf_gain, .high_shelf_corner, .low_shelf_gain, .low_shelf_corner);
`default_nettype wire

// File: test/testbench.sv
// Self-checking bench for the config bank
`timescale 1ns/100ps
`default_nettype none
module testbench;
  logic        hclk = 1'b0;
  logic        hresetn = 1'b0;
  logic        hsel = 1'b0;
  logic [31:0] haddr = 32'h0000_0000;
  logic [1:0]  htrans = 2'b00;
  logic        hwrite = 1'b0;
  logic [31:0] hwdata = 32'h0000_0000;
  logic        overcurrent_detect = 1'b0;
  logic        overtemp_detect = 1'b0;
  logic [31:0] rdata;
  int          n_fail = 0;
  int          comparisons = 0;
  int          cyc = 0;
  wire logic        hreadyout, hresp, power_stage_float;
  wire logic [31:0] hrdata;
  wire logic [4:0]  band_cfg_flag_one, band_cfg_flag_two, band_scale_factor;
  wire logic [54:0] band_coef_one_mantissa;
  wire logic [19:0] band_coef_one_exponent, band_coef_two_mantissa;
  wire logic [14:0] band_coef_two_exponent;
  wire logic [34:0] band_gain_param;
  wire logic        clip_smoothing_bypass, highpass_bypass, compressor_bypass, equalizer_bypass;
  wire logic [3:0]  attack_level, attack_speed, release_level, release_speed;
  wire logic [4:0]  high_shelf_gain, low_shelf_gain;
  wire logic [1:0]  high_shelf_corner, low_shelf_corner;

  always #4 hclk = ~hclk;

  // Short float counts keep the run brief
  adcr_config_regs #(.OCP_LONG_CYC(50), .OTP_MID_CYC(80), .OTP_LONG_CYC(120)) i_dut
  (
    .hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize(3'b010), .hwdata,
    .hready(hreadyout), .hreadyout, .hresp, .hrdata, .overcurrent_detect, .overtemp_detect,
    .power_stage_float, .band_cfg_flag_one, .band_coef_one_mantissa, .band_coef_one_exponent,
    .band_cfg_flag_two, .band_coef_two_mantissa, .band_coef_two_exponent, .band_gain_param,
    .band_scale_factor, .clip_smoothing_bypass, .highpass_bypass, .compressor_bypass,
    .equalizer_bypass, .attack_level, .attack_speed, .release_level, .release_speed,
    .high_shelf_gain, .high_shelf_corner, .low_shelf_gain, .low_shelf_corner
  );

  task automatic complete_run;
    $display("Comparisons %0d, mismatches %0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : complete_run

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    comparisons++;
    if (got !== exp)
    begin
      $display("[ERR] %s expected %h seen %h", what, exp, got);
      n_fail++;
    end
  endtask : chk

  // Decides at the negedge whether the coming edge has hready high
  task automatic wait_rdy;
    @(negedge hclk);
    while (hreadyout !== 1'b1)
      @(negedge hclk);
    rdata = hrdata;
    @(posedge hclk);
  endtask : wait_rdy

  task automatic xfer(input logic wr, input logic [31:0] a, input logic [15:0] d);
    hsel <= 1'b1;
    haddr <= a;
    htrans <= 2'b10;
    hwrite <= wr;
    wait_rdy();
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= {16'h0000, d};
    wait_rdy();
  endtask : xfer

  task automatic rd_chk(input logic [31:0] a, input logic [31:0] exp);
    xfer(1'b0, a, 16'h0000);
    chk($sformatf("reg %h", a), exp, rdata);
  endtask : rd_chk

  task automatic float_len(input logic ot, input int exp);
    int n;
    n = 0;
    if (ot)
      overtemp_detect <= 1'b1;
    else
      overcurrent_detect <= 1'b1;
    repeat (3) @(posedge hclk);
    overcurrent_detect <= 1'b0;
    overtemp_detect <= 1'b0;
    while (power_stage_float !== 1'b1 && n < 40)
    begin
      @(negedge hclk);
      n++;
    end
    n = 0;
    while (power_stage_float === 1'b1 && n < 5000)
    begin
      @(negedge hclk);
      n++;
    end
    chk("float cycles", exp, n);
    @(posedge hclk);
  endtask : float_len

  function automatic logic [15:0] pat(input int i);
    return 16'(16'h3C5A + 16'h2D17 * i);
  endfunction : pat

  always @(posedge hclk)
  begin
    cyc++;
    if (cyc == 30000)
    begin
      n_fail++;
      complete_run();
    end
  end

  initial
  begin
    repeat (2) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    rd_chk(32'h0000_003C, 32'h0000_0093);
    rd_chk(32'h0000_0040, 32'h0000_92BA);
    rd_chk(32'h0000_0044, 32'h0000_12A5);
    for (int i = 0; i < 10; i++)
      rd_chk(32'(32'h14 + 4 * i), 32'h0000_0000);
    $display("Test reset done");
    for (int i = 0; i < 10; i++)
      xfer(1'b1, 32'(32'h14 + 4 * i), pat(i));
    for (int i = 0; i < 10; i++)
      rd_chk(32'(32'h14 + 4 * i), {16'h0000, pat(i)});
    for (int b = 0; b < 5; b++)
    begin
      chk("band word one", {16'h0000, pat(2 * b)}, {16'h0000, band_cfg_flag_one[b],
        band_coef_one_mantissa[b * 11 +: 11], band_coef_one_exponent[b * 4 +: 4]});
      chk("band word two", {16'h0000, pat(2 * b + 1)}, {16'h0000, band_cfg_flag_two[b],
        band_coef_two_mantissa[b * 4 +: 4], band_coef_two_exponent[b * 3 +: 3],
        band_gain_param[b * 7 +: 7], band_scale_factor[b]});
    end
    $display("Test equalizer done");
    xfer(1'b1, 32'h0000_003C, 16'hFF0C);
    rd_chk(32'h0000_003C, 32'h0000_000C);
    chk("path bits", 32'h0000_000C, {28'h0, clip_smoothing_bypass, highpass_bypass,
      compressor_bypass, equalizer_bypass});
    xfer(1'b1, 32'h0000_003D, 16'hFFFF);
    xfer(1'b1, 32'h0000_0084, 16'hFFFF);
    rd_chk(32'h0000_003C, 32'h0000_000C);
    rd_chk(32'h0000_0084, 32'h0000_0000);
    xfer(1'b1, 32'h0000_0044, 16'hFFFF);
    rd_chk(32'h0000_0044, 32'h0000_3FFF);
    xfer(1'b1, 32'h0000_0044, 16'h2448);
    // Write lands on the edge xfer returns at; look once it has settled
    @(negedge hclk);
    chk("tone pins", 32'h0000_2448, {18'h0, high_shelf_gain, high_shelf_corner,
      low_shelf_gain, low_shelf_corner});
    @(posedge hclk);
    xfer(1'b1, 32'h0000_0040, 16'h5A3C);
    rd_chk(32'h0000_0040, 32'h0000_5A3C);
    chk("compressor pins", 32'h0000_5A3C, {16'h0, attack_level, attack_speed,
      release_level, release_speed});
    $display("Test fields done");
    xfer(1'b1, 32'h0000_003C, 16'h000C);
    float_len(1'b0, 563);
    float_len(1'b1, 563);
    xfer(1'b1, 32'h0000_003C, 16'h001C);
    float_len(1'b1, 80);
    xfer(1'b1, 32'h0000_003C, 16'h004C);
    float_len(1'b0, 3438);
    xfer(1'b1, 32'h0000_003C, 16'h008C);
    float_len(1'b0, 50);
    xfer(1'b1, 32'h0000_003C, 16'h002C);
    float_len(1'b1, 120);
    xfer(1'b1, 32'h0000_003C, 16'h00CC);
    float_len(1'b0, 5000);
    rd_chk(32'h0000_0080, 32'h0000_0001);
    hresetn <= 1'b0;
    repeat (2) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    chk("float after reset", 32'h0000_0000, {31'h0, power_stage_float});
    rd_chk(32'h0000_003C, 32'h0000_0093);
    $display("Test protection done");
    complete_run();
  end
endmodule : testbench
`default_nettype wire
